// ---- src/dcb_pkg.sv ----
// constants and types shared by the ddr command and bank logic
package dcb_pkg;
  localparam int unsigned BANKS        = 4;
  localparam int unsigned ADDR_W       = 13;
  localparam int unsigned DQ_W         = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned LANES        = 2;
  // pin command codes {ras_b, cas_b, we_b}
  localparam logic [2:0] CMD_NOP       = 3'h7;
  localparam logic [2:0] CMD_BST       = 3'h6;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_ACT       = 3'h3;
  localparam logic [2:0] CMD_PRE       = 3'h2;
  localparam logic [2:0] CMD_REF       = 3'h1;
  localparam logic [2:0] CMD_MODE      = 3'h0;
  // address field positions
  localparam int unsigned AP_BIT       = 10;
  localparam int unsigned DLL_BIT      = 0;
  localparam int unsigned BL_LSB       = 0;
  localparam int unsigned AMODE_BIT    = 3;
  localparam int unsigned CL_LSB       = 4;
  // mode encodings
  localparam logic [1:0] BA_MODE       = 2'h0;
  localparam logic [1:0] BA_EXT_MODE   = 2'h1;
  localparam logic [2:0] BL_2          = 3'h1;
  localparam logic [2:0] BL_4          = 3'h2;
  localparam logic [2:0] BL_8          = 3'h3;
  localparam logic [2:0] CL_2          = 3'h2;
  localparam logic [2:0] CL_3          = 3'h3;
  localparam logic [2:0] CL_25         = 3'h6;
  // reset values of the mode state, and the saturation limit of the tras counter
  localparam logic [2:0] RST_BL        = 3'h1;
  localparam logic [2:0] RST_CL        = 3'h2;
  localparam logic       RST_AMODE     = 1'b0;
  localparam logic       RST_DLL_OFF   = 1'b1;
  localparam logic [7:0] TRAS_CNT_MAX  = 8'hFF;
  // timing
  localparam int unsigned CLK_PERIOD_NS       = 25;
  localparam int unsigned REFRESH_INTERVAL_NS = 7800;
  localparam int unsigned REFRESH_INTERVAL_CK = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PW_NORMAL,
    PW_POWER_DOWN,
    PW_SELF_REFRESH
  } dcb_power_type;
endpackage

// ---- src/dcb_sync.sv ----
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dcb_sync #(
  parameter int unsigned WIDTH = 8
)(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             en_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else if (en_i)
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // dcb_sync
`default_nettype wire

// ---- src/dcb_store.sv ----
// cell array with per-byte write masking
`timescale 1ns/1ps
`default_nettype none
module dcb_store
  import dcb_pkg::*;
#(
  parameter int unsigned IDX_W = 6
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              en_i,
  // write port
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [DQ_W-1:0]   wr_data_i,
  input  wire logic [LANES-1:0]  wr_mask_i,
  // read port
  input  wire logic [IDX_W-1:0]  rd_idx_i,
  output logic      [DQ_W-1:0]   rd_data_o
);
  logic [DQ_W-1:0] cell_r [2**IDX_W];

  genvar gl;
  for (gl = 0; gl < LANES; gl++)
  begin : g_lane
    // a high mask keeps the old byte
    always_ff @(posedge clk_i)
    begin
      if (en_i && wr_en_i && !wr_mask_i[gl])
        cell_r[wr_idx_i][gl*BYTE_W +: BYTE_W] <= wr_data_i[gl*BYTE_W +: BYTE_W];
    end
  end

  assign rd_data_o = cell_r[rd_idx_i];
endmodule // dcb_store
`default_nettype wire

// ---- src/dcb_ddr_cmd_bank.sv ----
// command decode, bank state, bursts, refresh and power modes of the ddr device
//
// Contract
// - extended mode set carries only dll enable
// - nop with chip selected does nothing
// - burst stop ends reads, never writes
// - chip select high ignores all command pins
// - auto refresh steps internal row counter, idle banks
// - self refresh gates buffers, dll, refreshes itself
// - byte masks gate each lane per word
// - read returns burst after cas latency
// - precharge to bursting bank ends burst
// - read auto precharge idles bank after burst
// - write captures burst on both strobe edges
// - write auto precharge idles bank after burst
// - single precharge idles only addressed bank
// - precharge all idles only active banks
// - precharged read stops after cas latency
// - precharged write resets input immediately
// - self refresh entered idle, held while low
// - power down on clock enable low, no burst
// - precharge code, a10 selects all banks
// - read auto precharge waits half burst, tras
`timescale 1ns/1ps
`default_nettype none
module dcb_ddr_cmd_bank
  import dcb_pkg::*;
#(
  parameter int unsigned TRAS_MIN_CK = 6,
  parameter int unsigned TWR_CK      = 2,
  parameter int unsigned COL_W       = 4
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              en_i,
  // command pins
  input  wire logic              ddr_ck_i,
  input  wire logic              ddr_cke_i,
  input  wire logic              ddr_cs_b_i,
  input  wire logic              ddr_ras_b_i,
  input  wire logic              ddr_cas_b_i,
  input  wire logic              ddr_we_b_i,
  input  wire logic [ADDR_W-1:0] ddr_addr_i,
  input  wire logic [1:0]        ddr_bank_select_i,
  // data pins
  input  wire logic [DQ_W-1:0]   ddr_dq_i,
  output logic      [DQ_W-1:0]   ddr_dq_o,
  output logic                   ddr_dq_oe_o,
  input  wire logic              ddr_dqs_i,
  output logic                   ddr_dqs_o,
  output logic                   ddr_dqs_oe_o,
  input  wire logic              lower_byte_mask_i,
  input  wire logic              upper_byte_mask_i,
  // status
  output logic      [BANKS-1:0]  bank_active_o,
  output logic      [ADDR_W-1:0] refresh_row_o,
  output logic                   self_refresh_o,
  output logic                   power_down_o,
  output logic                   dll_on_o,
  output logic                   read_burst_o,
  output logic                   write_burst_o
);
  localparam int unsigned SW    = 6 + ADDR_W + 2 + DQ_W + LANES + 1;
  localparam int unsigned IDX_W = 2 + COL_W;

  // pin synchronisation
  logic [SW-1:0]     pin_raw;
  logic [SW-1:0]     pin_s;
  logic              ck_s;
  logic              cke_s;
  logic              cs_b_s;
  logic [2:0]        cmd_s;
  logic [ADDR_W-1:0] addr_s;
  logic [1:0]        ba_s;
  logic [DQ_W-1:0]   dq_s;
  logic [LANES-1:0]  dm_s;
  logic              dqs_s;

  assign pin_raw = {ddr_ck_i, ddr_cke_i, ddr_cs_b_i, ddr_ras_b_i, ddr_cas_b_i, ddr_we_b_i,
                    ddr_addr_i, ddr_bank_select_i, ddr_dq_i,
                    upper_byte_mask_i, lower_byte_mask_i, ddr_dqs_i};

  dcb_sync #(.WIDTH(SW)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .en_i    (en_i),
    .d_i     (pin_raw),
    .q_o     (pin_s)
  );

  assign {ck_s, cke_s, cs_b_s, cmd_s, addr_s, ba_s, dq_s, dm_s, dqs_s} = pin_s;

  // edge detection on the sampled link clock and strobe
  logic ck_d_r;
  logic dqs_d_r;
  logic cke_prev_r;
  logic ck_rise;
  logic ck_edge;
  logic dqs_edge;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ck_d_r     <= 1'b0;
      dqs_d_r    <= 1'b0;
      cke_prev_r <= 1'b0;
    end
    else if (en_i)
    begin
      ck_d_r  <= ck_s;
      dqs_d_r <= dqs_s;
      if (ck_rise)
        cke_prev_r <= cke_s;
    end
  end

  assign ck_rise  = ck_s & ~ck_d_r;
  assign ck_edge  = ck_s ^ ck_d_r;
  assign dqs_edge = dqs_s ^ dqs_d_r;

  // mode state
  dcb_power_type pw_r;
  dcb_power_type pw_nxt;
  logic [2:0]    bl_code_r;
  logic [2:0]    cl_code_r;
  logic          amode_r;
  logic          dll_off_r;
  logic [3:0]    bl_words;
  logic [3:0]    bl_half;
  logic [3:0]    cl_half;

  always_comb
  begin
    case (bl_code_r)
      BL_4:    bl_words = 4'h4;
      BL_8:    bl_words = 4'h8;
      default: bl_words = 4'h2;
    endcase
    case (cl_code_r)
      CL_25:   cl_half = 4'h5;
      CL_3:    cl_half = 4'h6;
      default: cl_half = 4'h4;
    endcase
  end

  assign bl_half = bl_words >> 1;

  // command decode
  logic [BANKS-1:0] bank_act_w;
  logic [BANKS-1:0] pre_hit;
  logic             all_idle;
  logic             cmd_live;
  logic             is_act;
  logic             is_read;
  logic             is_write;
  logic             is_pre;
  logic             is_bst;
  logic             is_aref;
  logic             is_mode;
  logic             sr_enter;
  logic             pd_enter;
  logic             burst_idle;
  logic [3:0]       rd_left_r;
  logic [3:0]       wr_left_r;

  assign all_idle   = (bank_act_w == '0);
  assign burst_idle = (rd_left_r == 4'h0) && (wr_left_r == 4'h0);
  // deselect and nop fall through with no effect
  assign cmd_live   = ck_rise && (pw_r == PW_NORMAL) && cke_prev_r && cke_s && !cs_b_s;
  assign is_act     = cmd_live && (cmd_s == CMD_ACT);
  assign is_read    = cmd_live && (cmd_s == CMD_READ) && bank_act_w[ba_s];
  assign is_write   = cmd_live && (cmd_s == CMD_WRITE) && bank_act_w[ba_s];
  assign is_pre     = cmd_live && (cmd_s == CMD_PRE);
  assign is_bst     = cmd_live && (cmd_s == CMD_BST) && (rd_left_r != 4'h0);
  assign is_aref    = cmd_live && (cmd_s == CMD_REF) && all_idle;
  assign is_mode    = cmd_live && (cmd_s == CMD_MODE) && all_idle;
  assign sr_enter   = ck_rise && (pw_r == PW_NORMAL) && cke_prev_r && !cke_s && !cs_b_s
                      && (cmd_s == CMD_REF) && all_idle && burst_idle;
  assign pd_enter   = ck_rise && (pw_r == PW_NORMAL) && cke_prev_r && !cke_s
                      && (cs_b_s || (cmd_s[2:1] == 2'h3)) && burst_idle;

  // mode and extended mode set
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bl_code_r <= RST_BL;
      cl_code_r <= RST_CL;
      amode_r   <= RST_AMODE;
      dll_off_r <= RST_DLL_OFF;
    end
    else if (en_i && is_mode)
    begin
      if (ba_s == BA_MODE)
      begin
        bl_code_r <= addr_s[BL_LSB +: 3];
        amode_r   <= addr_s[AMODE_BIT];
        cl_code_r <= addr_s[CL_LSB +: 3];
      end
      else if (ba_s == BA_EXT_MODE)
        dll_off_r <= addr_s[DLL_BIT];
    end
  end

  // power mode state
  always_comb
  begin
    pw_nxt = pw_r;
    case (pw_r)
      PW_NORMAL:
      begin
        if (sr_enter)
          pw_nxt = PW_SELF_REFRESH;
        else if (pd_enter)
          pw_nxt = PW_POWER_DOWN;
      end
      PW_POWER_DOWN:
      begin
        if (ck_rise && cke_s)
          pw_nxt = PW_NORMAL;
      end
      PW_SELF_REFRESH:
      begin
        // held while clock enable is low
        if (ck_rise && cke_s && (cs_b_s || (cmd_s[2:1] == 2'h3)))
          pw_nxt = PW_NORMAL;
      end
      default: pw_nxt = PW_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pw_r           <= PW_NORMAL;
      self_refresh_o <= 1'b0;
      power_down_o   <= 1'b0;
      dll_on_o       <= 1'b0;
    end
    else if (en_i)
    begin
      pw_r           <= pw_nxt;
      self_refresh_o <= (pw_nxt == PW_SELF_REFRESH);
      power_down_o   <= (pw_nxt == PW_POWER_DOWN);
      dll_on_o       <= !dll_off_r && (pw_nxt == PW_NORMAL);
    end
  end

  // refresh row counter and self refresh timer
  logic [15:0] sr_tmr_r;
  logic        sr_tick;

  assign sr_tick = (pw_r == PW_SELF_REFRESH) && (sr_tmr_r == 16'(REFRESH_INTERVAL_CK - 1));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sr_tmr_r      <= 16'h0000;
      refresh_row_o <= '0;
    end
    else if (en_i)
    begin
      if ((pw_r != PW_SELF_REFRESH) || sr_tick)
        sr_tmr_r <= 16'h0000;
      else
        sr_tmr_r <= sr_tmr_r + 16'h0001;
      if (is_aref || sr_tick)
        refresh_row_o <= refresh_row_o + 1'b1;
    end
  end

  // per-bank state and auto precharge
  genvar gb;
  for (gb = 0; gb < BANKS; gb++)
  begin : g_bank
    logic       active_r;
    logic [7:0] tras_r;
    logic       ap_armed_r;
    logic [4:0] ap_cnt_r;
    logic       ap_fire;
    logic       ap_hit;

    assign pre_hit[gb] = is_pre && (addr_s[AP_BIT] || (ba_s == 2'(gb))) && active_r;
    assign ap_hit      = (is_read || is_write) && addr_s[AP_BIT] && (ba_s == 2'(gb));
    assign ap_fire     = ap_armed_r && (ap_cnt_r == 5'h00)
                         && (tras_r >= 8'(TRAS_MIN_CK));

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        active_r   <= 1'b0;
        tras_r     <= 8'h00;
        ap_armed_r <= 1'b0;
        ap_cnt_r   <= 5'h00;
      end
      else if (en_i && ck_rise)
      begin
        if (is_act && (ba_s == 2'(gb)) && !active_r)
        begin
          active_r <= 1'b1;
          tras_r   <= 8'h00;
        end
        else if (pre_hit[gb] || ap_fire)
        begin
          active_r   <= 1'b0;
          ap_armed_r <= 1'b0;
        end
        else
        begin
          if (tras_r != TRAS_CNT_MAX)
            tras_r <= tras_r + 8'h01;
          if (ap_hit)
          begin
            ap_armed_r <= 1'b1;
            // writes also wait write latency and recovery
            ap_cnt_r   <= is_read ? 5'(bl_half) : 5'(32'(bl_half) + 1 + TWR_CK);
          end
          else if (ap_armed_r && (ap_cnt_r != 5'h00))
            ap_cnt_r <= ap_cnt_r - 5'h01;
        end
      end
    end

    assign bank_active_o[gb] = active_r;
    assign bank_act_w[gb]    = active_r;
  end

  // burst column sequencing
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
                                                  input logic [2:0]       idx,
                                                  input logic [3:0]       words,
                                                  input logic             interleave);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] step;
    mask = COL_W'(words - 4'h1);
    step = COL_W'(idx);
    if (interleave)
      burst_col = base ^ step;
    else
      burst_col = (base & ~mask) | ((base + step) & mask);
  endfunction

  // read burst
  logic [3:0]       rd_wait_r;
  logic             rd_stop_r;
  logic [3:0]       rd_stop_wait_r;
  logic [1:0]       rd_bank_r;
  logic [COL_W-1:0] rd_base_r;
  logic [2:0]       rd_idx_r;
  logic             rd_kill;
  logic [DQ_W-1:0]  rd_data;

  assign rd_kill = is_bst || (is_pre && (addr_s[AP_BIT] || (ba_s == rd_bank_r)));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_wait_r      <= 4'h0;
      rd_left_r      <= 4'h0;
      rd_stop_r      <= 1'b0;
      rd_stop_wait_r <= 4'h0;
      rd_bank_r      <= 2'h0;
      rd_base_r      <= '0;
      rd_idx_r       <= 3'h0;
      ddr_dq_o       <= '0;
      ddr_dq_oe_o    <= 1'b0;
      ddr_dqs_o      <= 1'b0;
      ddr_dqs_oe_o   <= 1'b0;
      read_burst_o   <= 1'b0;
    end
    else if (en_i && ck_edge)
    begin
      ddr_dq_oe_o  <= 1'b0;
      ddr_dqs_oe_o <= 1'b0;
      if (is_read)
      begin
        rd_wait_r <= cl_half - 4'h1;
        rd_left_r <= bl_words;
        rd_stop_r <= 1'b0;
        rd_bank_r <= ba_s;
        rd_base_r <= addr_s[COL_W-1:0];
        rd_idx_r  <= 3'h0;
      end
      else if (rd_left_r != 4'h0)
      begin
        if (rd_kill && !rd_stop_r)
        begin
          rd_stop_r      <= 1'b1;
          rd_stop_wait_r <= cl_half - 4'h1;
        end
        else if (rd_stop_r && (rd_stop_wait_r != 4'h0))
          rd_stop_wait_r <= rd_stop_wait_r - 4'h1;
        if (rd_stop_r && (rd_stop_wait_r == 4'h0))
          rd_left_r <= 4'h0;
        else if (rd_wait_r != 4'h0)
          rd_wait_r <= rd_wait_r - 4'h1;
        else
        begin
          // one word per link clock edge, strobe edge aligned
          ddr_dq_o     <= rd_data;
          ddr_dq_oe_o  <= 1'b1;
          ddr_dqs_o    <= ck_rise;
          ddr_dqs_oe_o <= 1'b1;
          rd_left_r    <= rd_left_r - 4'h1;
          rd_idx_r     <= rd_idx_r + 3'h1;
        end
      end
      read_burst_o <= is_read || (rd_left_r > 4'h1);
    end
  end

  // write burst
  logic             wr_wait_r;
  logic [1:0]       wr_bank_r;
  logic [COL_W-1:0] wr_base_r;
  logic [2:0]       wr_idx_r;
  logic             wr_kill;
  logic             wr_take;

  assign wr_kill = is_pre && (addr_s[AP_BIT] || (ba_s == wr_bank_r)) && (wr_left_r != 4'h0);
  assign wr_take = dqs_edge && !wr_wait_r && (wr_left_r != 4'h0) && !wr_kill
                   && (pw_r == PW_NORMAL);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_wait_r     <= 1'b0;
      wr_left_r     <= 4'h0;
      wr_bank_r     <= 2'h0;
      wr_base_r     <= '0;
      wr_idx_r      <= 3'h0;
      write_burst_o <= 1'b0;
    end
    else if (en_i)
    begin
      if (is_write)
      begin
        // first strobe edge comes after the next clock rise
        wr_wait_r <= 1'b1;
        wr_left_r <= bl_words;
        wr_bank_r <= ba_s;
        wr_base_r <= addr_s[COL_W-1:0];
        wr_idx_r  <= 3'h0;
      end
      else if (wr_kill)
        wr_left_r <= 4'h0;
      else
      begin
        if (ck_rise)
          wr_wait_r <= 1'b0;
        if (wr_take)
        begin
          wr_left_r <= wr_left_r - 4'h1;
          wr_idx_r  <= wr_idx_r + 3'h1;
        end
      end
      write_burst_o <= is_write || (!wr_kill && (wr_left_r > 4'(wr_take)));
    end
  end

  dcb_store #(.IDX_W(IDX_W)) u_store (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .en_i      (en_i),
    .wr_en_i   (wr_take),
    .wr_idx_i  ({wr_bank_r, burst_col(wr_base_r, wr_idx_r, bl_words, amode_r)}),
    .wr_data_i (dq_s),
    .wr_mask_i (dm_s),
    .rd_idx_i  ({rd_bank_r, burst_col(rd_base_r, rd_idx_r, bl_words, amode_r)}),
    .rd_data_o (rd_data)
  );
endmodule // dcb_ddr_cmd_bank
`default_nettype wire

// ---- sim/dcb_ddr_cmd_bank_asserts.sv ----
// port checker for the ddr command and bank logic
`timescale 1ns/1ps
`default_nettype none
module dcb_ddr_cmd_bank_asserts
  import dcb_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // watched pins
  input  wire logic              ddr_cs_b_i,
  input  wire logic              ddr_dq_oe_o,
  input  wire logic              ddr_dqs_oe_o,
  input  wire logic [BANKS-1:0]  bank_active_o,
  input  wire logic [ADDR_W-1:0] refresh_row_o,
  input  wire logic              self_refresh_o,
  input  wire logic              power_down_o,
  input  wire logic              dll_on_o,
  input  wire logic              read_burst_o,
  input  wire logic              write_burst_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_sr_dll; self_refresh_o |-> !dll_on_o; endproperty
  a_sr_dll: assert property (p_sr_dll) else $error("dll on in self refresh");
  property p_sr_in;
    $rose(self_refresh_o) |-> $past(bank_active_o) == '0 && !$past(read_burst_o)
      && !$past(write_burst_o);
  endproperty
  a_sr_in: assert property (p_sr_in) else $error("self refresh entered busy");
  property p_pd_dll; power_down_o |-> !dll_on_o; endproperty
  a_pd_dll: assert property (p_pd_dll) else $error("dll on in power down");
  property p_pd_in; $rose(power_down_o) |-> !$past(read_burst_o) && !$past(write_burst_o);
  endproperty
  a_pd_in: assert property (p_pd_in) else $error("power down during burst");
  property p_row; !$stable(refresh_row_o) |-> refresh_row_o == $past(refresh_row_o) + 13'h1;
  endproperty
  a_row: assert property (p_row) else $error("refresh row jumped");
  property p_desel; ddr_cs_b_i [*6] |=> (bank_active_o & ~$past(bank_active_o)) == '0;
  endproperty
  a_desel: assert property (p_desel) else $error("bank opened while deselected");
  property p_strobe; ddr_dq_oe_o |-> ddr_dqs_oe_o; endproperty
  a_strobe: assert property (p_strobe) else $error("read data without strobe");
  property p_quiet; ddr_dq_oe_o |-> !self_refresh_o && !power_down_o; endproperty
  a_quiet: assert property (p_quiet) else $error("data out in low power");
endmodule // dcb_ddr_cmd_bank_asserts
bind dcb_ddr_cmd_bank dcb_ddr_cmd_bank_asserts i_chk (.clk_i, .rst_b_i, .ddr_cs_b_i,
  .ddr_dq_oe_o, .ddr_dqs_oe_o, .bank_active_o, .refresh_row_o, .self_refresh_o,
  .power_down_o, .dll_on_o, .read_burst_o, .write_burst_o);
`default_nettype wire

// ---- sim/dcb_ctl_model.sv ----
// behavioural memory controller on the ddr pins
`timescale 1ns/1ps
`default_nettype none
module dcb_ctl_model
  import dcb_pkg::*;
(
  // command pins
  output logic              ck_o,
  output logic              cke_o,
  output logic              cs_b_o,
  output logic [2:0]        cmd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [1:0]        ba_o,
  // write data pins
  output logic [DQ_W-1:0]   dq_o,
  output logic              dqs_o,
  output logic [LANES-1:0]  mask_o
);
  initial
  begin
    {cke_o, cs_b_o, cmd_o} = {2'b01, CMD_NOP};
    {addr_o, ba_o, dq_o, dqs_o, mask_o} = {13'h0000, 2'h0, 16'h0000, 1'b0, 2'h0};
    ck_o = 1'b0;
    #37;
    forever #100 ck_o = ~ck_o;
  end
  // pins change at link fall, taken at the next rise
  task cmd(input logic cke, input logic cs_b, input logic [2:0] c,
           input logic [ADDR_W-1:0] a, input logic [1:0] b);
    @(negedge ck_o);
    {cke_o, cs_b_o, cmd_o, addr_o, ba_o} = {cke, cs_b, c, a, b};
    @(posedge ck_o);
  endtask
  // deselect gaps give settle time after refresh and exits
  task idle(input int n, input logic cke);
    repeat (n) cmd(cke, 1'b1, CMD_NOP, ~addr_o, ~ba_o);
  endtask
  // bursts of four words, two per link cycle on both strobe edges
  task wr(input logic [1:0] b, input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] base,
          input logic [7:0] m);
    cmd(1'b1, 1'b0, CMD_WRITE, a, b);
    @(negedge ck_o);
    {cs_b_o, cmd_o} = {1'b1, CMD_NOP};
    for (int k = 0; k < 4; k += 2)
    begin
      @(posedge ck_o);
      #25 {dq_o, mask_o} = {base + DQ_W'(k * 257), m[2*k +: 2]};
      #25 dqs_o = 1'b1;
      #50 {dq_o, mask_o} = {base + DQ_W'((k + 1) * 257), m[2*k+2 +: 2]};
      #50 dqs_o = 1'b0;
    end
    #25 dq_o = ~dq_o;
  endtask
endmodule // dcb_ctl_model
`default_nettype wire

// ---- sim/dcb_ddr_cmd_bank_bench.sv ----
// self-checking bench for the ddr command and bank logic
`timescale 1ns/1ps
`default_nettype none
module dcb_ddr_cmd_bank_bench
  import dcb_pkg::*;
;
  typedef struct {
    logic cs_b; logic [2:0] c; logic [12:0] a; logic [1:0] b;
    logic [3:0] act; logic [12:0] row; logic dll;
  } dcb_row_type;
  logic              clk_i, rst_b_i, ck, cke, cs_b, dqs, dqs_o, dqs_oe, dq_oe;
  logic              sr, pd, dll, rb, wb, oe_q, dqs_q;
  logic [2:0]        cmd;
  logic [1:0]        ba, mask;
  logic [12:0]       addr, row;
  logic [15:0]       dq, dq_o;
  logic [3:0]        bank_act;
  logic [15:0]       rdq[$];
  logic [15:0]       ex[4];
  int                err_count, n_compared, cyc;
  dcb_row_type rows[11] = '{
    '{0, CMD_MODE, 13'h0000, 2'h1, 4'h0, 13'h0000, 1},
    '{0, CMD_MODE, 13'h0022, 2'h0, 4'h0, 13'h0000, 1},
    '{0, CMD_ACT,  13'h0000, 2'h0, 4'h1, 13'h0000, 1},
    '{0, CMD_ACT,  13'h0005, 2'h2, 4'h5, 13'h0000, 1},
    '{1, CMD_ACT,  13'h0000, 2'h1, 4'h5, 13'h0000, 1},
    '{0, CMD_NOP,  13'h0000, 2'h1, 4'h5, 13'h0000, 1},
    '{0, CMD_PRE,  13'h0000, 2'h0, 4'h4, 13'h0000, 1},
    '{0, CMD_REF,  13'h0000, 2'h0, 4'h4, 13'h0000, 1},
    '{0, CMD_PRE,  13'h0400, 2'h3, 4'h0, 13'h0000, 1},
    '{0, CMD_REF,  13'h0000, 2'h0, 4'h0, 13'h0001, 1},
    '{0, CMD_REF,  13'h0000, 2'h0, 4'h0, 13'h0002, 1}};
  dcb_ctl_model ctl (.ck_o(ck), .cke_o(cke), .cs_b_o(cs_b), .cmd_o(cmd), .addr_o(addr),
    .ba_o(ba), .dq_o(dq), .dqs_o(dqs), .mask_o(mask));
  dcb_ddr_cmd_bank i_dut (.clk_i, .rst_b_i, .en_i(1'b1), .ddr_ck_i(ck), .ddr_cke_i(cke),
    .ddr_cs_b_i(cs_b), .ddr_ras_b_i(cmd[2]), .ddr_cas_b_i(cmd[1]), .ddr_we_b_i(cmd[0]),
    .ddr_addr_i(addr), .ddr_bank_select_i(ba), .ddr_dq_i(dq), .ddr_dq_o(dq_o),
    .ddr_dq_oe_o(dq_oe), .ddr_dqs_i(dqs), .ddr_dqs_o(dqs_o), .ddr_dqs_oe_o(dqs_oe),
    .lower_byte_mask_i(mask[0]), .upper_byte_mask_i(mask[1]), .bank_active_o(bank_act),
    .refresh_row_o(row), .self_refresh_o(sr), .power_down_o(pd), .dll_on_o(dll),
    .read_burst_o(rb), .write_burst_o(wb));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // one word per strobe level while read data is driven
  always @(posedge clk_i)
  begin
    if (dq_oe === 1'b1 && (oe_q !== 1'b1 || dqs_o !== dqs_q))
      rdq.push_back(dq_o);
    oe_q <= dq_oe;
    dqs_q <= dqs_o;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      end_sim();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // read at column 1 of bank 1, then kc at the next rise
  task rd(input logic [12:0] a, input logic [2:0] kc, input int n);
    rdq.delete();
    ctl.cmd(1'b1, 1'b0, CMD_READ, a, 2'h1);
    ctl.cmd(1'b1, kc == CMD_NOP, kc, 13'h0000, 2'h1);
    ctl.idle(6, 1'b1);
    chk(16'(rdq.size()), 16'(n));
    for (int k = 0; k < n; k++)
      chk(rdq[k], ex[(k + 1) % 4]);
  endtask
  initial
  begin
    {rst_b_i, oe_q, dqs_q, cyc, err_count, n_compared} = '0;
    for (int k = 0; k < 4; k++)
      ex[k] = {k[1] ? 8'hA0 + 8'(k) : 8'h50 + 8'(k), k[0] ? 8'hF0 + 8'(k) : 8'h00 + 8'(k)};
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk({bank_act, row[11:0]}, 16'h0000);
    chk({dll, sr, pd, rb, wb, dq_oe, 10'h000}, 16'h0000);
    ctl.idle(3, 1'b1);
    foreach (rows[i])
    begin
      ctl.cmd(1'b1, rows[i].cs_b, rows[i].c, rows[i].a, rows[i].b);
      ctl.idle(2, 1'b1);
      chk(16'(bank_act), 16'(rows[i].act));
      chk(16'(row), 16'(rows[i].row));
      chk(16'(dll), 16'(rows[i].dll));
    end
    $display("command table done");
    ctl.cmd(1'b1, 1'b0, CMD_ACT, 13'h0000, 2'h1);
    ctl.idle(6, 1'b1);
    ctl.wr(2'h1, 13'h0000, 16'hA0F0, 8'h00);
    ctl.idle(2, 1'b1);
    ctl.wr(2'h1, 13'h0400, 16'h5000, 8'hE4);
    ctl.idle(8, 1'b1);
    chk(16'(bank_act), 16'h0000);
    ctl.cmd(1'b1, 1'b0, CMD_ACT, 13'h0000, 2'h1);
    ctl.idle(6, 1'b1);
    rd(13'h0001, CMD_NOP, 4);
    rd(13'h0001, CMD_BST, 2);
    chk(16'(bank_act), 16'h0002);
    rd(13'h0401, CMD_NOP, 4);
    chk(16'(bank_act), 16'h0000);
    ctl.cmd(1'b1, 1'b0, CMD_ACT, 13'h0000, 2'h1);
    ctl.idle(6, 1'b1);
    rd(13'h0001, CMD_PRE, 2);
    chk(16'(bank_act), 16'h0000);
    $display("bursts done");
    ctl.cmd(1'b0, 1'b0, CMD_REF, 13'h0000, 2'h0);
    ctl.idle(2, 1'b0);
    chk({15'h0, sr}, 16'h0001);
    chk({15'h0, dll}, 16'h0000);
    ctl.idle(45, 1'b0);
    chk(16'(row), 16'h0003);
    ctl.idle(2, 1'b1);
    chk({14'h0, sr, dll}, 16'h0001);
    ctl.cmd(1'b0, 1'b1, CMD_NOP, 13'h0000, 2'h0);
    ctl.cmd(1'b0, 1'b0, CMD_ACT, 13'h0000, 2'h3);
    ctl.idle(2, 1'b0);
    chk({11'h0, pd, bank_act}, 16'h0010);
    ctl.idle(2, 1'b1);
    chk({15'h0, pd}, 16'h0000);
    $display("low power done");
    ctl.cmd(1'b1, 1'b0, CMD_ACT, 13'h0000, 2'h0);
    ctl.idle(2, 1'b1);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({11'h0, dll, bank_act}, 16'h0000);
    rst_b_i = 1'b1;
    $display("reset done");
    end_sim();
  end
endmodule // dcb_ddr_cmd_bank_bench
`default_nettype wire
